// ===== rtl/humc_pkg.sv
// Constants shared by the host serial link and mode control block
package humc_pkg;
    // Clock and line rates
    localparam int CLK_HZ       = 100_000_000;
    localparam int RATE_SLOW    = 57600;
    localparam int RATE_FAST    = 460800;
    localparam int DIV_W        = 11;
    localparam logic [DIV_W-1:0] DIV_SLOW = DIV_W'(CLK_HZ / RATE_SLOW);
    localparam logic [DIV_W-1:0] DIV_FAST = DIV_W'(CLK_HZ / RATE_FAST);

    // Character framing: start, eight data bits, one stop, no parity
    localparam int            DATA_BITS = 8;
    localparam logic [3:0]    BIT_STOP  = 4'h9;

    // Start-up timing, in milliseconds
    localparam int             MS_NS       = 1_000_000;
    localparam int             MS_CYCLES_DEF = MS_NS / 10;
    localparam logic [15:0]    INIT_MS     = 16'h0032;
    localparam logic [15:0]    BOOT_DELAY_MS_DEF = 16'h00C8;

    // Pin input filter indices
    localparam int PIN_RX    = 0;
    localparam int PIN_STRAP = 1;
    localparam int PIN_RESET = 2;
    localparam int PIN_N     = 3;

    // Functional states
    typedef enum logic [2:0] {
        ST_INIT  = 3'h0,
        ST_READY = 3'h1,
        ST_RX    = 3'h2,
        ST_IDLE  = 3'h3,
        ST_TX    = 3'h4,
        ST_SLEEP = 3'h5
    } humc_state_t;
endpackage : humc_pkg

// ===== rtl/humc_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module humc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    // Drain side
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;
    logic             push;
    logic             pop;

    assign push       = in_valid_i && in_ready_o;
    assign pop        = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rd_ptr_q];

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wr_ptr_q    <= '0;
            rd_ptr_q    <= '0;
            cnt_q       <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
            end
            cnt_q       <= cnt_d;
            in_ready_o  <= (cnt_d != CW'(DEPTH));
            out_valid_o <= (cnt_d != '0);
        end
    end
endmodule : humc_fifo

// ===== rtl/humc_top.sv
// Host serial link, line-rate control and functional state control
`timescale 1ns/1ps
module humc_top
    import humc_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and power-on reset
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    // Device pins
    input  wire logic       reset_in_n_i,
    input  wire logic       fast_rate_strap_n_i,
    input  wire logic       uart_rx_i,
    output logic            uart_tx_o,
    // Bytes toward the host
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    // Bytes from the host
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    output logic            rx_frame_err_o,
    // Commands decoded from the host protocol
    input  wire logic       set_line_rate_cmd_i,
    input  wire logic       set_line_rate_fast_i,
    input  wire logic       write_boot_delay_cmd_i,
    input  wire logic [15:0] boot_delay_ms_i,
    // Radio side control
    input  wire logic       tx_only_i,
    input  wire logic       radio_tx_req_i,
    input  wire logic       radio_tx_done_i,
    input  wire logic       sleep_req_i,
    input  wire logic       wake_i,
    // Status
    output humc_state_t     state_o,
    output logic            rx_enable_o,
    output logic            rate_fast_o,
    output logic [15:0]     boot_delay_ms_o
);
    // Pin filters: four flops, a change counts once stages two and three agree
    logic [PIN_N-1:0] sync1_q;
    logic [PIN_N-1:0] sync2_q;
    logic [PIN_N-1:0] sync3_q;
    logic [PIN_N-1:0] pin_q;
    logic [PIN_N-1:0] pin_raw;

    assign pin_raw = {reset_in_n_i, fast_rate_strap_n_i, uart_rx_i};

    for (genvar g = 0; g < PIN_N; g++) begin : g_pin
        always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
                sync1_q[g] <= 1'b1;
                sync2_q[g] <= 1'b1;
                sync3_q[g] <= 1'b1;
                pin_q[g]   <= 1'b1;
            end else begin
                sync1_q[g] <= pin_raw[g];
                sync2_q[g] <= sync1_q[g];
                sync3_q[g] <= sync2_q[g];
                if (sync2_q[g] == sync3_q[g]) begin
                    pin_q[g] <= sync3_q[g];
                end
            end
        end
    end

    // Device reset; the boot delay survives it, and only the power-on reset reloads the default
    logic rst_n;
    assign rst_n = resetn_i && pin_q[PIN_RESET];

    // Persistent boot delay
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            boot_delay_ms_o <= BOOT_DELAY_MS_DEF;
        end else if (write_boot_delay_cmd_i) begin
            boot_delay_ms_o <= boot_delay_ms_i;
        end
    end

    // Millisecond timebase for init and boot delay
    logic [$clog2(MS_CYCLES+1)-1:0] ms_div_q;
    logic                           ms_tick;
    logic [15:0]                    ms_cnt_q;
    humc_state_t                    state_d;

    assign ms_tick = (ms_div_q == $bits(ms_div_q)'(MS_CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (!rst_n || state_d != state_o) begin
            ms_div_q <= '0;
            ms_cnt_q <= '0;
        end else if (ms_tick) begin
            ms_div_q <= '0;
            ms_cnt_q <= ms_cnt_q + 16'h0001;
        end else begin
            ms_div_q <= ms_div_q + $bits(ms_div_q)'(1);
        end
    end

    // Functional state sequence
    logic op_state;
    assign op_state = tx_only_i ? 1'b0 : 1'b1;

    always_comb begin
        state_d = state_o;
        unique case (state_o)
            ST_INIT: begin
                if (ms_tick && ms_cnt_q == INIT_MS - 16'h0001) begin
                    state_d = ST_READY;
                end
            end
            ST_READY: begin
                if (ms_cnt_q >= boot_delay_ms_o) begin
                    state_d = op_state ? ST_RX : ST_IDLE;
                end
            end
            ST_RX, ST_IDLE: begin
                if (radio_tx_req_i) begin
                    state_d = ST_TX;
                end else if (sleep_req_i) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_TX: begin
                if (radio_tx_done_i) begin
                    state_d = op_state ? ST_RX : ST_IDLE;
                end
            end
            ST_SLEEP: begin
                if (wake_i) begin
                    state_d = op_state ? ST_RX : ST_IDLE;
                end
            end
            default: state_d = ST_INIT;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n) begin
            state_o     <= ST_INIT;
            rx_enable_o <= 1'b0;
        end else begin
            state_o     <= state_d;
            rx_enable_o <= (state_d == ST_RX);
        end
    end

    // Line rate: strap taken as init ends, command wins at any time
    logic             strap_done_q;
    logic [DIV_W-1:0] div_now;

    assign div_now = rate_fast_o ? DIV_FAST : DIV_SLOW;

    always_ff @(posedge clk_i) begin
        if (!rst_n) begin
            rate_fast_o  <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (set_line_rate_cmd_i) begin
            rate_fast_o  <= set_line_rate_fast_i;
            strap_done_q <= 1'b1;
        end else if (!strap_done_q && state_o == ST_INIT && state_d == ST_READY) begin
            rate_fast_o  <= !pin_q[PIN_STRAP];
            strap_done_q <= 1'b1;
        end
    end

    // Transmit path toward the host drains the FIFO
    logic [7:0]       fifo_data;
    logic             fifo_valid;
    logic             tx_busy_q;
    logic [9:0]       tx_sh_q;
    logic [3:0]       tx_bit_q;
    logic [DIV_W-1:0] tx_cnt_q;
    logic [DIV_W-1:0] tx_div_q;
    logic             tx_take;

    assign tx_take = fifo_valid && !tx_busy_q;

    humc_fifo #(
        .WIDTH (DATA_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i       (clk_i),
        .resetn_i    (rst_n),
        .in_data_i   (tx_data_i),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (tx_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (!tx_busy_q)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_n) begin
            tx_busy_q <= 1'b0;
            tx_sh_q   <= 10'h3FF;
            tx_bit_q  <= 4'h0;
            tx_cnt_q  <= '0;
            tx_div_q  <= DIV_SLOW;
            uart_tx_o <= 1'b1;
        end else if (tx_take) begin
            // Rate is latched per character so a change never splits one
            tx_busy_q <= 1'b1;
            tx_sh_q   <= {1'b1, fifo_data, 1'b0};
            tx_bit_q  <= 4'h0;
            tx_cnt_q  <= div_now - DIV_W'(1);
            tx_div_q  <= div_now;
            uart_tx_o <= 1'b0;
        end else if (tx_busy_q) begin
            if (tx_cnt_q == '0) begin
                tx_cnt_q <= tx_div_q - DIV_W'(1);
                if (tx_bit_q == BIT_STOP) begin
                    tx_busy_q <= 1'b0;
                    uart_tx_o <= 1'b1;
                end else begin
                    tx_bit_q  <= tx_bit_q + 4'h1;
                    tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
                    uart_tx_o <= tx_sh_q[1];
                end
            end else begin
                tx_cnt_q <= tx_cnt_q - DIV_W'(1);
            end
        end
    end

    // Receive path from the host, sampled mid-bit
    logic             rx_busy_q;
    logic [3:0]       rx_bit_q;
    logic [DIV_W-1:0] rx_cnt_q;
    logic [DIV_W-1:0] rx_div_q;
    logic [7:0]       rx_sh_q;
    logic             rx_line;

    assign rx_line = pin_q[PIN_RX];

    always_ff @(posedge clk_i) begin
        if (!rst_n) begin
            rx_busy_q      <= 1'b0;
            rx_bit_q       <= 4'h0;
            rx_cnt_q       <= '0;
            rx_div_q       <= DIV_SLOW;
            rx_sh_q        <= 8'h00;
            rx_data_o      <= 8'h00;
            rx_valid_o     <= 1'b0;
            rx_frame_err_o <= 1'b0;
        end else begin
            rx_valid_o     <= 1'b0;
            rx_frame_err_o <= 1'b0;
            if (!rx_busy_q) begin
                if (!rx_line) begin
                    rx_busy_q <= 1'b1;
                    rx_bit_q  <= 4'h0;
                    rx_cnt_q  <= div_now >> 1;
                    rx_div_q  <= div_now;
                end
            end else if (rx_cnt_q != '0) begin
                rx_cnt_q <= rx_cnt_q - DIV_W'(1);
            end else begin
                rx_cnt_q <= rx_div_q - DIV_W'(1);
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == 4'h0) begin
                    // A start bit gone high at mid-bit was a glitch
                    rx_busy_q <= !rx_line;
                end else if (rx_bit_q == BIT_STOP) begin
                    rx_busy_q      <= 1'b0;
                    rx_data_o      <= rx_sh_q;
                    rx_valid_o     <= rx_line;
                    rx_frame_err_o <= !rx_line;
                end else begin
                    rx_sh_q <= {rx_line, rx_sh_q[7:1]};
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_init_end;
        state_o == ST_INIT && ms_tick && ms_cnt_q == INIT_MS - 16'h0001;
    endsequence

    sequence s_tx_finish;
        state_o == ST_TX && radio_tx_done_i && !tx_only_i;
    endsequence

    a_init_to_ready: assert property (s_init_end |=> state_o == ST_READY)
        else $error("init did not end in Ready");
    a_tx_back_rx: assert property (s_tx_finish |=> state_o == ST_RX ##1 rx_enable_o)
        else $error("transmit did not return to receive");
    a_idle_rx_off: assert property (state_o == ST_IDLE |-> !rx_enable_o)
        else $error("receive enabled in Idle");
    a_rate_cmd: assert property (set_line_rate_cmd_i |=>
        rate_fast_o == $past(set_line_rate_fast_i))
        else $error("rate command not applied");
    a_strap_rate: assert property (s_init_end and !strap_done_q and !set_line_rate_cmd_i
        |=> rate_fast_o == !$past(pin_q[PIN_STRAP]))
        else $error("strap rate not taken");
    a_boot_write: assert property (write_boot_delay_cmd_i |=>
        boot_delay_ms_o == $past(boot_delay_ms_i))
        else $error("boot delay not stored");
    a_ready_wait: assert property (state_o == ST_READY && ms_cnt_q < boot_delay_ms_o
        |=> state_o == ST_READY)
        else $error("left Ready before delay");
    a_start_bit: assert property ($rose(tx_busy_q) |-> !uart_tx_o
        ##1 (!uart_tx_o)[*2])
        else $error("start bit missing");
    a_stop_bit: assert property (tx_busy_q && tx_bit_q == BIT_STOP |-> uart_tx_o)
        else $error("stop bit not high");
    a_rate_pair: assert property (tx_take |=>
        tx_div_q == ($past(rate_fast_o) ? DIV_FAST : DIV_SLOW))
        else $error("character rate not latched");
    a_tx_div_hold: assert property (tx_busy_q |=> $stable(tx_div_q))
        else $error("rate changed inside a sent character");
    a_rx_div_hold: assert property (rx_busy_q |=> $stable(rx_div_q))
        else $error("rate changed inside a received character");
    a_tx_enter: assert property (radio_tx_req_i &&
        (state_o == ST_RX || state_o == ST_IDLE) |=> state_o == ST_TX)
        else $error("transmit request not taken");
    a_sleep_wake: assert property (state_o == ST_SLEEP && wake_i |=>
        state_o == ($past(tx_only_i) ? ST_IDLE : ST_RX))
        else $error("wake did not resume the configured mode");
endmodule : humc_top

// ===== bench/humc_host_model.sv
// Host side of the serial link: sends characters and collects the device's
`timescale 1ns/1ps
module humc_host_model
    import humc_pkg::*;
(
    // Clock
    input  wire logic clk_i,
    // Line rate the host is set to
    input  wire logic fast_i,
    // Serial lines
    input  wire logic uart_tx_i,
    output logic      uart_rx_o
);
    logic [7:0] got_q[$];
    int         bad_stop = 0;

    // The host only ever runs one of the two supported rates
    function automatic int bit_cycles(input logic fast);
        return fast ? int'(DIV_FAST) : int'(DIV_SLOW);
    endfunction : bit_cycles

    initial uart_rx_o = 1'b1;

    // One character, LSB first; a low stop bit makes a framing fault
    task automatic send(input logic [7:0] b, input logic stop_ok);
        logic [9:0] f;
        f = {stop_ok, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_i);
            #1 uart_rx_o = (i < 10) ? f[i] : 1'b1;
            repeat (bit_cycles(fast_i) - 1) @(posedge clk_i);
        end
        // Return off the edge so the caller's next change is not raced
        #1;
    endtask : send

    // Sample at mid-bit, as a host UART would
    initial begin : collect
        logic [7:0] b;
        int         d;
        forever begin
            @(negedge uart_tx_i);
            d = bit_cycles(fast_i);
            repeat (d / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (d) @(posedge clk_i);
                b[i] = uart_tx_i;
            end
            repeat (d) @(posedge clk_i);
            if (uart_tx_i !== 1'b1) bad_stop++;
            got_q.push_back(b);
        end
    end
endmodule : humc_host_model

// ===== bench/testbench.sv
// Self-checking bench for the host link and mode control block
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
    $display("[ERR] %0t got=%0h exp=%0h", $time, (a), (e)); end end
module testbench;
    import humc_pkg::*;
    // Short millisecond keeps INIT at 500 cycles and the default boot at 2000
    localparam int MSC = 10;
    logic        clk_i, resetn_i, reset_in_n_i, fast_rate_strap_n_i, uart_rx_i, uart_tx_o;
    logic [7:0]  tx_data_i, rx_data_o;
    logic        tx_valid_i, tx_ready_o, rx_valid_o, rx_frame_err_o;
    logic        set_line_rate_cmd_i, set_line_rate_fast_i, write_boot_delay_cmd_i;
    logic [15:0] boot_delay_ms_i, boot_delay_ms_o;
    logic        tx_only_i, radio_tx_req_i, radio_tx_done_i, sleep_req_i, wake_i;
    humc_state_t state_o;
    logic        rx_enable_o, rate_fast_o, host_fast;
    int          err_total, check_count, seed, ferr_n;
    logic [7:0]  exp_q[$], rx_q[$];

    humc_top #(.MS_CYCLES(MSC), .FIFO_DEPTH(8)) DUT (
        .clk_i, .resetn_i, .reset_in_n_i, .fast_rate_strap_n_i, .uart_rx_i, .uart_tx_o,
        .tx_data_i, .tx_valid_i, .tx_ready_o, .rx_data_o, .rx_valid_o, .rx_frame_err_o,
        .set_line_rate_cmd_i, .set_line_rate_fast_i, .write_boot_delay_cmd_i,
        .boot_delay_ms_i, .tx_only_i, .radio_tx_req_i, .radio_tx_done_i, .sleep_req_i,
        .wake_i, .state_o, .rx_enable_o, .rate_fast_o, .boot_delay_ms_o
    );
    humc_host_model host (.clk_i, .fast_i(host_fast), .uart_tx_i(uart_tx_o),
                          .uart_rx_o(uart_rx_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (rx_valid_o === 1'b1) rx_q.push_back(rx_data_o);
        if (rx_frame_err_o === 1'b1) ferr_n++;
    end

    function automatic humc_state_t run_state(input logic tx_only);
        return tx_only ? ST_IDLE : ST_RX;
    endfunction : run_state

    function automatic int char_cycles(input logic fast);
        return 10 * (fast ? int'(DIV_FAST) : int'(DIV_SLOW));
    endfunction : char_cycles

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    task automatic wait_st(input humc_state_t st, input int lim);
        for (int i = 0; i < lim && state_o !== st; i++) step(1);
        `CHK(state_o, st)
    endtask : wait_st

    task automatic pulse(input logic [3:0] m);
        {radio_tx_req_i, radio_tx_done_i, sleep_req_i, wake_i} = m;
        step(1);
        {radio_tx_req_i, radio_tx_done_i, sleep_req_i, wake_i} = 4'h0;
        step(1);
    endtask : pulse

    task automatic set_rate(input logic fast);
        set_line_rate_cmd_i = 1'b1;
        set_line_rate_fast_i = fast;
        step(1);
        set_line_rate_cmd_i = 1'b0;
        host_fast = fast;
        step(1);
    endtask : set_rate

    // Valid and data stay put until the edge that sees ready high
    task automatic push(input logic [7:0] b);
        int n;
        n = 0;
        tx_data_i = b;
        tx_valid_i = 1'b1;
        while (tx_ready_o !== 1'b1 && n < 30000) begin
            step(1);
            n++;
        end
        `CHK(tx_ready_o, 1'b1)
        step(1);
        exp_q.push_back(b);
    endtask : push

    task automatic wait_got(input int n, input int lim);
        for (int i = 0; i < lim && host.got_q.size() < n; i++) step(1);
        `CHK(host.got_q.size(), n)
    endtask : wait_got

    task automatic end_sim();
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    initial begin
        // Tests take about 67k cycles; give up at 90k
        #900_000;
        err_total++;
        end_sim();
    end

    initial begin
        logic [7:0] b;
        seed = 32'h59ae;
        {resetn_i, reset_in_n_i, fast_rate_strap_n_i, tx_valid_i, host_fast} = 5'h0C;
        tx_data_i = 8'h00;
        {set_line_rate_cmd_i, set_line_rate_fast_i, write_boot_delay_cmd_i} = 3'h0;
        boot_delay_ms_i = 16'h0000;
        {tx_only_i, radio_tx_req_i, radio_tx_done_i, sleep_req_i, wake_i} = 5'h00;
        step(4);
        `CHK(state_o, ST_INIT)
        `CHK(boot_delay_ms_o, BOOT_DELAY_MS_DEF)
        `CHK(uart_tx_o, 1'b1)
        resetn_i = 1'b1;
        step(480);
        `CHK(state_o, ST_INIT)
        wait_st(ST_READY, 40);
        `CHK(rate_fast_o, 1'b0)
        step(1960);
        `CHK(state_o, ST_READY)
        wait_st(run_state(1'b0), 60);
        step(1);
        `CHK(rx_enable_o, 1'b1)
        push(8'($random(seed)));
        tx_valid_i = 1'b0;
        wait_got(1, char_cycles(1'b0) + 100);
        set_rate(1'b1);
        `CHK(rate_fast_o, 1'b1)
        for (int i = 0; i < 9; i++) push(i == 0 ? 8'h00 : i == 8 ? 8'hFF : 8'($random(seed)));
        tx_valid_i = 1'b0;
        step(1);
        `CHK(tx_ready_o, 1'b0)
        wait_got(10, 9 * char_cycles(1'b1) + 200);
        step(1);
        `CHK(tx_ready_o, 1'b1)
        foreach (exp_q[i]) `CHK(host.got_q[i], exp_q[i])
        `CHK(host.bad_stop, 0)
        exp_q.delete();
        for (int i = 0; i < 3; i++) begin
            b = i == 0 ? 8'h80 : 8'($random(seed));
            if (i < 2) exp_q.push_back(b);
            host.send(b, i < 2);
        end
        set_rate(1'b0);
        exp_q.push_back(8'h3C);
        host.send(8'h3C, 1'b1);
        step(20);
        `CHK(rx_q.size(), 3)
        foreach (exp_q[i]) `CHK(rx_q[i], exp_q[i])
        `CHK(ferr_n, 1)
        pulse(4'b1010);
        `CHK(state_o, ST_TX)
        pulse(4'b0100);
        `CHK(state_o, run_state(1'b0))
        pulse(4'b0010);
        `CHK(state_o, ST_SLEEP)
        `CHK(rx_enable_o, 1'b0)
        pulse(4'b0001);
        `CHK(state_o, ST_RX)
        tx_only_i = 1'b1;
        pulse(4'b1000);
        pulse(4'b0100);
        `CHK(state_o, run_state(1'b1))
        `CHK(rx_enable_o, 1'b0)
        write_boot_delay_cmd_i = 1'b1;
        boot_delay_ms_i = 16'h0003;
        step(1);
        write_boot_delay_cmd_i = 1'b0;
        step(1);
        `CHK(boot_delay_ms_o, 16'h0003)
        fast_rate_strap_n_i = 1'b0;
        reset_in_n_i = 1'b0;
        step(8);
        `CHK(state_o, ST_INIT)
        `CHK(rate_fast_o, 1'b0)
        `CHK(boot_delay_ms_o, 16'h0003)
        reset_in_n_i = 1'b1;
        wait_st(ST_READY, 520);
        step(1);
        `CHK(rate_fast_o, 1'b1)
        host_fast = 1'b1;
        wait_st(run_state(1'b1), 40);
        set_rate(1'b0);
        `CHK(rate_fast_o, 1'b0)
        end_sim();
    end
endmodule : testbench
